// *** gpp_defines.svh ***
// Register indices, field positions, reset values for the port block.
// Assumes APB byte addresses equal four times each index.
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// Register indices (byte address is four times the index)
`define GPP_IDX_FIRST_DATA 10'h006
`define GPP_IDX_THIRD_DATA 10'h007
`define GPP_IDX_FOURTH_DATA 10'h008
`define GPP_IDX_FIFTH_DATA 10'h009
`define GPP_IDX_OPTION 10'h081
`define GPP_IDX_FIRST_DIR 10'h086
`define GPP_IDX_THIRD_DIR 10'h087
`define GPP_IDX_FOURTH_DIR 10'h088
`define GPP_IDX_FIFTH_DIR 10'h089
`define GPP_IDX_IRQ_FLAG 10'h08C
`define GPP_IDX_ANALOG_CFG 10'h09F

// Fifth direction / slave control fields, then the option pull-up bit
`define GPP_BIT_IN_FULL 7
`define GPP_BIT_OUT_FULL 6
`define GPP_BIT_IN_OVF 5
`define GPP_BIT_SLAVE_SEL 4
`define GPP_BIT_PULLUP_OFF 7

// Fifth pin roles in slave mode
`define GPP_PIN_RD 0
`define GPP_PIN_WR 1
`define GPP_PIN_CS 2

// Reset values
`define GPP_RST_DIR 8'hFF
`define GPP_RST_OPTION 8'hFF
`define GPP_RST_FIFTH_DIR 3'h7
`define GPP_RST_ANALOG 3'h0

`endif

// *** gpp_ext_master.sv ***
// External byte-wide master on the slave port: strobes and data bus drive.
// Assumes the bench resolves fourth-port pins from oe_n and this drive.
module gpp_ext_master (
   input wire logic pclk,
   input wire logic [7:0] fourth_out,
   input wire logic [7:0] fourth_oe_n,
   output logic [7:0] bus_drv,
   output logic [2:0] ctl_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle: strobes and chip select high
   initial begin
      bus_drv = 8'h5A;
      ctl_n = 3'h7;
   end
   // Write cycle, data held past the strobe release
   task automatic ext_write(input logic [7:0] d);
      bus_drv <= d;
      ctl_n <= 3'h1;
      repeat (4) @(posedge pclk);
      ctl_n <= 3'h7;
      repeat (4) @(posedge pclk);
      bus_drv <= ~d; // Released bus shows the inverse
      repeat (2) @(posedge pclk);
   endtask
   // Read cycle, byte taken while the device drives
   task automatic ext_read(output logic [7:0] q);
      ctl_n <= 3'h2;
      for (int k = 0; k < 8 && fourth_oe_n !== 8'h00; k++) @(posedge pclk);
      @(posedge pclk);
      q = (fourth_out & ~fourth_oe_n) | (bus_drv & fourth_oe_n); // Byte seen on the pins
      ctl_n <= 3'h7;
      repeat (5) @(posedge pclk);
   endtask
endmodule

// *** gpp_pkg.sv ***
// Types shared by the port block.
// Assumes nothing beyond a SystemVerilog compiler.
package gpp_pkg;
   typedef enum logic [1:0] {GPP_IDLE, GPP_WRITING, GPP_READING} gpp_psp_state_t;
   typedef logic [7:0] gpp_byte_t;
endpackage

// *** gpp_ports.sv ***
// Four general ports, slave-port mode on the fourth, APB register access.
// Assumes pins are resolved outside from out/oe_n; strobes are asynchronous.
// Functional notes
// - third port is 8-bit, each pin direction set by its direction bit.
// - enabled peripheral overrides third-port pin direction, forcing output or input.
// - fourth port is 8-bit, each pin direction individually configurable.
// - slave select bit 4 of fifth direction register enables slave port.
// - fifth port has three individually directed pins doubling as strobes.
// - with slave select set, fifth pins act as slave control inputs; here their direction bits still steer them.
// - fifth pins selected analog read back as zero.
// - fifth direction bits still steer pins while analog is selected.
// - after power-on reset fifth pins are analog and read zero.
// - read strobe low with chip selected drives fourth output latch onto pins.
// - write strobe low with chip selected latches fourth pins into input latch.
// - chip select is active low; high leaves the port unselected.
// - port data latches are unknown at power-on and otherwise unchanged.
// - full direction registers reset to all ones, every pin input.
// - set direction bit floats the pin; clear bit drives output latch.
// - in slave mode the fourth direction register is ignored.
// - finished external write sets input-full and irq; cpu read clears input-full.
// - read start clears output-full; stays clear until software writes output.
//
// Chosen here: the APB register port.
module gpp_ports #(
   parameter int PORT_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [PORT_W-1:0] first_in,
   output logic [PORT_W-1:0] first_out,
   output logic [PORT_W-1:0] first_oe_n,
   output logic [PORT_W-1:0] first_pullup_en,
   input wire logic [PORT_W-1:0] third_in,
   output logic [PORT_W-1:0] third_out,
   output logic [PORT_W-1:0] third_oe_n,
   input wire logic [PORT_W-1:0] periph_ovr_en,
   input wire logic [PORT_W-1:0] periph_ovr_in,
   input wire logic [PORT_W-1:0] fourth_in,
   output logic [PORT_W-1:0] fourth_out,
   output logic [PORT_W-1:0] fourth_oe_n,
   input wire logic [2:0] fifth_in,
   output logic [2:0] fifth_out,
   output logic [2:0] fifth_oe_n,
   output logic slave_port_irq
);
   import gpp_pkg::*;
`include "gpp_defines.svh"

   // Refuse widths the 8-bit register map cannot hold
   // Narrower ports leave the upper register bits reading zero
   if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
      $error("PORT_W must be 1 to 8");
   end

   // Register map, byte address is four times the index
   // 0x006 first data: pins read, output latch written
   // 0x007 third data: pins read, output latch written
   // 0x008 fourth data: pins, or input latch in slave mode
   // 0x009 fifth data: three pins, zero while analog
   // 0x081 option: bit 7 high turns first pull-ups off
   // 0x086 to 0x088 direction of first, third, fourth port
   // 0x089 fifth direction, slave select and slave flags
   // Layout of 0x089: bit 7 input-full, bit 6 output-full,
   // bit 5 overflow, bit 4 slave select, bit 3 zero, 2:0 direction
   // 0x08C transfer-complete flag, write one to clear
   // 0x09F analog configuration, three bits
   // Unmapped indices answer with an error and read zero
   // Upper data bits read zero and are ignored on write

   // Registers
   logic [PORT_W-1:0] first_data_q;
   logic [PORT_W-1:0] third_data_q;
   logic [PORT_W-1:0] fourth_data_q;
   logic [PORT_W-1:0] fourth_in_latch_q;
   logic [2:0] fifth_data_q;
   logic [PORT_W-1:0] first_dir_q;
   logic [PORT_W-1:0] third_dir_q;
   logic [PORT_W-1:0] fourth_dir_q;
   logic [2:0] fifth_dir_q;
   logic [2:0] acfg_q;
   gpp_byte_t option_q;
   logic slave_sel_q;
   logic in_full_q;
   logic out_full_q;
   logic in_ovf_q;
   logic irq_flag_q;
   logic [31:0] prdata_q;
   gpp_psp_state_t psp_q;

   // Pin synchronisers
   // Only the second stage of each pair feeds any logic
   logic [PORT_W-1:0] first_s1_q;
   logic [PORT_W-1:0] first_s2_q;
   logic [PORT_W-1:0] third_s1_q;
   logic [PORT_W-1:0] third_s2_q;
   logic [PORT_W-1:0] fourth_s1_q;
   logic [PORT_W-1:0] fourth_s2_q;
   logic [2:0] fifth_s1_q;
   logic [2:0] fifth_s2_q;

   // Bus decode
   // No wait states: pready follows the clock enable
   // A low clock enable stretches the access phase
   logic [9:0] idx;
   logic setup;
   logic wr_done;
   logic rd_done;
   logic mapped;
   assign idx = paddr[11:2];
   assign setup = psel & ~penable;
   assign wr_done = psel & penable & pwrite & ce;
   assign rd_done = psel & penable & ~pwrite & ce;
   assign pready = ce;
   assign prdata = prdata_q;

   // Decoded write strobes
   logic w_first;
   logic w_third;
   logic w_fourth;
   logic w_fifth;
   logic w_opt;
   logic w_dfirst;
   logic w_dthird;
   logic w_dfourth;
   logic w_dfifth;
   logic w_irq;
   logic w_acfg;
   logic r_fourth;
   assign w_first = wr_done && idx == `GPP_IDX_FIRST_DATA;
   assign w_third = wr_done && idx == `GPP_IDX_THIRD_DATA;
   assign w_fourth = wr_done && idx == `GPP_IDX_FOURTH_DATA;
   assign w_fifth = wr_done && idx == `GPP_IDX_FIFTH_DATA;
   assign w_opt = wr_done && idx == `GPP_IDX_OPTION;
   assign w_dfirst = wr_done && idx == `GPP_IDX_FIRST_DIR;
   assign w_dthird = wr_done && idx == `GPP_IDX_THIRD_DIR;
   assign w_dfourth = wr_done && idx == `GPP_IDX_FOURTH_DIR;
   assign w_dfifth = wr_done && idx == `GPP_IDX_FIFTH_DIR;
   assign w_irq = wr_done && idx == `GPP_IDX_IRQ_FLAG;
   assign w_acfg = wr_done && idx == `GPP_IDX_ANALOG_CFG;
   assign r_fourth = rd_done && idx == `GPP_IDX_FOURTH_DATA;

   // Address map membership
   always_comb begin
      case (idx)
         `GPP_IDX_FIRST_DATA,
         `GPP_IDX_THIRD_DATA,
         `GPP_IDX_FOURTH_DATA,
         `GPP_IDX_FIFTH_DATA,
         `GPP_IDX_OPTION,
         `GPP_IDX_FIRST_DIR,
         `GPP_IDX_THIRD_DIR,
         `GPP_IDX_FOURTH_DIR,
         `GPP_IDX_FIFTH_DIR,
         `GPP_IDX_IRQ_FLAG,
         `GPP_IDX_ANALOG_CFG: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~mapped;

   // Two-flop pin synchronisers
   // Pins and strobes are asynchronous; two flops tame metastability
   // Fifth flops reset high, the idle strobe level, so no false strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_s1_q <= '0;
         first_s2_q <= '0;
         third_s1_q <= '0;
         third_s2_q <= '0;
         fourth_s1_q <= '0;
         fourth_s2_q <= '0;
         fifth_s1_q <= 3'h7;
         fifth_s2_q <= 3'h7;
      end else if (ce) begin
         first_s1_q <= first_in;
         first_s2_q <= first_s1_q;
         third_s1_q <= third_in;
         third_s2_q <= third_s1_q;
         fourth_s1_q <= fourth_in;
         fourth_s2_q <= fourth_s1_q;
         fifth_s1_q <= fifth_in;
         fifth_s2_q <= fifth_s1_q;
      end
   end

   // Digital view of fifth pins; analog pins read zero
   logic fifth_digital;
   logic [2:0] fifth_rd;
   assign fifth_digital = acfg_q[2] & acfg_q[1];
   assign fifth_rd = fifth_digital ? fifth_s2_q : 3'h0;

   // Slave strobes, seen only after synchronising
   logic cs_act;
   logic wr_act;
   logic rd_act;
   assign cs_act = slave_sel_q & ~fifth_s2_q[`GPP_PIN_CS];
   assign wr_act = cs_act & ~fifth_s2_q[`GPP_PIN_WR];
   assign rd_act = cs_act & ~fifth_s2_q[`GPP_PIN_RD];

   // Data latches: no reset, so unknown at power-on and kept otherwise
   // The reset input does not count as power-on, so a later pulse of it
   // leaves every latch holding its last value
   // Write the latch before clearing a direction bit
   always_ff @(posedge pclk) begin
      if (ce) begin
         if (w_first) first_data_q <= pwdata[PORT_W-1:0];
         if (w_third) third_data_q <= pwdata[PORT_W-1:0];
         if (w_fourth) fourth_data_q <= pwdata[PORT_W-1:0];
         if (w_fifth) fifth_data_q <= pwdata[2:0];
         if (wr_act) fourth_in_latch_q <= fourth_s2_q;
      end
   end

   // Direction, option and analog configuration registers
   // Reset: every direction bit set, so no pin drives
   // Option all ones, pull-ups off; analog configuration zero,
   // so the fifth pins start analog and read zero
   // Slave select clear; flags reset in their own processes
   // Data latches and synchronisers sit outside this process
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_dir_q <= '1;
         third_dir_q <= '1;
         fourth_dir_q <= '1;
         fifth_dir_q <= `GPP_RST_FIFTH_DIR;
         option_q <= `GPP_RST_OPTION;
         acfg_q <= `GPP_RST_ANALOG;
         slave_sel_q <= 1'b0;
      end else if (ce) begin
         if (w_dfirst) first_dir_q <= pwdata[PORT_W-1:0];
         if (w_dthird) third_dir_q <= pwdata[PORT_W-1:0];
         if (w_dfourth) fourth_dir_q <= pwdata[PORT_W-1:0];
         if (w_opt) option_q <= pwdata[7:0];
         if (w_acfg) acfg_q <= pwdata[2:0];
         if (w_dfifth) begin
            fifth_dir_q <= pwdata[2:0];
            slave_sel_q <= pwdata[`GPP_BIT_SLAVE_SEL];
         end
      end
   end

   // Slave transfer walk, strobes seen two edges late:
   // write: chip select and write strobe low, latch follows pins
   // write ends when either goes high; one edge later input-full
   // and the transfer-complete flag rise; a full latch overflows
   // read: chip select and read strobe low, output-full clears
   // one edge later; the output latch drives the fourth pins at once
   // read ends when either goes high; one edge later the
   // transfer-complete flag rises
   // A read that starts while a write is live waits for it to end, yet drives the fourth pins at once
   // Hazard: the strobes lag by two edges, so a master must keep
   // them low for at least three clock periods

   // Slave transfer sequencer
   logic wr_end;
   logic rd_start;
   logic rd_end;
   assign wr_end = psp_q == GPP_WRITING && !wr_act;
   assign rd_start = psp_q == GPP_IDLE && rd_act && !wr_act;
   assign rd_end = psp_q == GPP_READING && !rd_act;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psp_q <= GPP_IDLE;
      end else if (ce) begin
         case (psp_q)
            GPP_IDLE: begin
               if (wr_act) psp_q <= GPP_WRITING;
               else if (rd_act) psp_q <= GPP_READING;
            end
            GPP_WRITING: if (!wr_act) psp_q <= GPP_IDLE;
            GPP_READING: if (!rd_act) psp_q <= GPP_IDLE;
            default: psp_q <= GPP_IDLE;
         endcase
      end
   end

   // Input-full and overflow; set wins over clear
   // Input-full held clear outside slave mode; overflow stays until software
   // writes zero to its bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_full_q <= 1'b0;
         in_ovf_q <= 1'b0;
      end else if (ce) begin
         if (!slave_sel_q) in_full_q <= 1'b0;
         else if (wr_end) in_full_q <= 1'b1;
         else if (r_fourth) in_full_q <= 1'b0;
         if (wr_end && in_full_q && !r_fourth) in_ovf_q <= 1'b1;
         else if (w_dfifth && !pwdata[`GPP_BIT_IN_OVF]) in_ovf_q <= 1'b0;
      end
   end

   // Output-full: set by software write, cleared at read start
   // Held clear outside slave mode
   // A write in the read-start cycle leaves the flag clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_full_q <= 1'b0;
      end else if (ce) begin
         if (!slave_sel_q) out_full_q <= 1'b0;
         else if (rd_start) out_full_q <= 1'b0;
         else if (w_fourth) out_full_q <= 1'b1;
      end
   end

   // Transfer-complete flag; write 1 clears, hardware set wins
   // Set at the end of every slave read or write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_q <= 1'b0;
      end else if (ce) begin
         if (wr_end || rd_end) irq_flag_q <= 1'b1;
         else if (w_irq && pwdata[0]) irq_flag_q <= 1'b0;
      end
   end
   assign slave_port_irq = irq_flag_q;

   // Read data mux, captured in the setup phase
   // Early capture lets a read that clears input-full still
   // return the byte that set it
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (idx)
         `GPP_IDX_FIRST_DATA: rd_mux[PORT_W-1:0] = first_s2_q;
         `GPP_IDX_THIRD_DATA: rd_mux[PORT_W-1:0] = third_s2_q;
         `GPP_IDX_FOURTH_DATA: rd_mux[PORT_W-1:0] = slave_sel_q ? fourth_in_latch_q : fourth_s2_q;
         `GPP_IDX_FIFTH_DATA: rd_mux[2:0] = fifth_rd;
         `GPP_IDX_OPTION: rd_mux[7:0] = option_q;
         `GPP_IDX_FIRST_DIR: rd_mux[PORT_W-1:0] = first_dir_q;
         `GPP_IDX_THIRD_DIR: rd_mux[PORT_W-1:0] = third_dir_q;
         `GPP_IDX_FOURTH_DIR: rd_mux[PORT_W-1:0] = fourth_dir_q;
         `GPP_IDX_FIFTH_DIR: rd_mux[7:0] = {in_full_q, out_full_q, in_ovf_q, slave_sel_q,
                                             1'b0, fifth_dir_q};
         `GPP_IDX_IRQ_FLAG: rd_mux[0] = irq_flag_q;
         `GPP_IDX_ANALOG_CFG: rd_mux[2:0] = acfg_q;
         default: rd_mux = '0;
      endcase
   end

   // Read data register
   // Holds until the next read setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_q <= '0;
      else if (ce && setup && !pwrite) prdata_q <= rd_mux;
   end

   // First port drivers and pull-ups
   // Pull-up only on input pins, never on a driven one
   assign first_out = first_data_q;
   assign first_oe_n = first_dir_q;
   assign first_pullup_en = option_q[`GPP_BIT_PULLUP_OFF] ? '0 : first_dir_q;

   // Third port with peripheral direction override
   // Override bit: one makes the pin an input, zero an output
   // The direction register keeps its value under override
   genvar gi;
   for (gi = 0; gi < PORT_W; gi++) begin : g_third
      assign third_oe_n[gi] = periph_ovr_en[gi] ? periph_ovr_in[gi] : third_dir_q[gi];
   end
   assign third_out = third_data_q;

   // Fourth port: direction register, or the external master in slave mode
   // Strobe lag delays the slave drive by two edges
   assign fourth_out = fourth_data_q;
   assign fourth_oe_n = slave_sel_q ? {PORT_W{~rd_act}} : fourth_dir_q;

   // Fifth port: direction bits always rule, slave mode included
   // Software keeps these set while analog or in slave mode
   assign fifth_out = fifth_data_q;
   assign fifth_oe_n = fifth_dir_q;
endmodule

// *** gpp_ports_sva.sv ***
// Checker for the port block: APB answers, pin drive, override and flag clearing.
// Assumes it is bound to gpp_ports and sees only that module's ports.
module gpp_ports_sva #(
   parameter int PORT_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [PORT_W-1:0] first_out,
   input wire logic [PORT_W-1:0] first_oe_n,
   input wire logic [PORT_W-1:0] first_pullup_en,
   input wire logic [PORT_W-1:0] third_oe_n,
   input wire logic [PORT_W-1:0] periph_ovr_en,
   input wire logic [PORT_W-1:0] periph_ovr_in,
   input wire logic [PORT_W-1:0] fourth_out,
   input wire logic [PORT_W-1:0] fourth_oe_n,
   input wire logic [2:0] fifth_oe_n,
   input wire logic slave_port_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed APB write to one register index
   function automatic logic wr_at(input logic [9:0] i);
      return psel && penable && pwrite && ce && paddr[11:2] == i;
   endfunction
   chk_unmapped_err: assert property (psel && penable && paddr[11:2] == 10'h3FF
      |-> pslverr && (pwrite || prdata == 0))
      else $error("unmapped access not refused");
   chk_first_latch: assert property (wr_at(10'h006) |=> first_out == $past(pwdata[PORT_W-1:0]))
      else $error("first output latch not written");
   chk_fourth_latch: assert property (wr_at(10'h008) |=> fourth_out == $past(pwdata[PORT_W-1:0]))
      else $error("fourth output latch not written");
   chk_third_dir: assert property (wr_at(10'h087) ##1 periph_ovr_en == 0
      |-> third_oe_n == $past(pwdata[PORT_W-1:0]))
      else $error("third direction not applied");
   chk_fifth_dir: assert property (wr_at(10'h089) |=> fifth_oe_n == $past(pwdata[2:0]))
      else $error("fifth direction not applied");
   chk_ovr_forces: assert property ($stable(periph_ovr_en) && $stable(periph_ovr_in)
      |-> ((third_oe_n ^ periph_ovr_in) & periph_ovr_en) == 0)
      else $error("override does not steer third pin");
   chk_pullup_output: assert property ((first_pullup_en & ~first_oe_n) == 0)
      else $error("pull-up on while pin drives");
   chk_irq_clear: assert property ($fell(slave_port_irq) |-> $past(wr_at(10'h08C) && pwdata[0]))
      else $error("irq flag fell without clear write");
   cover property (pslverr);
   cover property ($rose(slave_port_irq));
   cover property (fourth_oe_n == 0);
endmodule

bind gpp_ports gpp_ports_sva #(.PORT_W(PORT_W)) i_sva (.*);

// *** gpp_ports_test.sv ***
// Self-checking bench for the port block over APB and the slave port.
// Assumes the design, checker and external master are compiled first.
module gpp_ports_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0] first_out, first_oe_n, third_out, third_oe_n, fourth_out, fourth_oe_n, bus_drv, d, q, o, oe, pu;
   logic [7:0] ext_b = 8'h00, ovr_en = 8'h00, ovr_in = 8'h00, rnd = 8'h48;
   logic [2:0] fifth_out, fifth_oe_n, ctl_n;
   int fails = 0, comparisons = 0, cyc = 0, m_if = 0, m_ov = 0;
   always #25 pclk = ~pclk;
   // Design with pins resolved from drive enables
   gpp_ports i_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .first_in((first_out & ~first_oe_n) | (ext_b & first_oe_n)), .first_out, .first_oe_n,
      .first_pullup_en(pu), .third_in((third_out & ~third_oe_n) | (ext_b & third_oe_n)), .third_out, .third_oe_n,
      .periph_ovr_en(ovr_en), .periph_ovr_in(ovr_in), .fourth_in((fourth_out & ~fourth_oe_n) | (bus_drv & fourth_oe_n)),
      .fourth_out, .fourth_oe_n, .fifth_in((fifth_out & ~fifth_oe_n) | (ctl_n & fifth_oe_n)), .fifth_out,
      .fifth_oe_n, .slave_port_irq(irq));
   gpp_ext_master i_ext (.pclk, .fourth_out, .fourth_oe_n, .bus_drv, .ctl_n);
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // One APB transfer; read data and error taken at the access edge
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= 32'(wd);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [9:0] i, input logic [31:0] e);
      apb(1'b0, i, 8'h00);
      cmp(n, e, rd);
   endtask
   // Expected fifth direction word from the flag model
   function automatic logic [31:0] fdir(input int of);
      return 32'({m_if[0], of[0], m_ov[0], 5'h17});
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("first dir", 10'h086, 32'h0000_00FF);
      rchk("third dir", 10'h087, 32'h0000_00FF);
      rchk("fourth dir", 10'h088, 32'h0000_00FF);
      rchk("fifth dir", 10'h089, 32'h0000_0007);
      rchk("fifth analog", 10'h009, 32'h0000_0000);
      rchk("unmapped", 10'h3FF, 32'h0000_0000);
      cmp("slverr", 32'h0000_0001, 32'(err));
      rchk("option", 10'h081, 32'h0000_00FF);
      apb(1'b1, 10'h081, 8'h00);
      // Random latch and direction on the first, third and fourth ports
      for (int p = 0; p < 3; p++) begin
         d = rnd;
         rnd = lfsr(rnd);
         ext_b <= ~d;
         apb(1'b1, 10'h006 + 10'(p), d);
         apb(1'b1, 10'h086 + 10'(p), rnd);
         {o, oe} = p == 0 ? {first_out, first_oe_n} : p == 1 ? {third_out, third_oe_n} : {fourth_out, fourth_oe_n};
         cmp("port out", 32'(d), 32'(o));
         cmp("port oe_n", 32'(rnd), 32'(oe));
         if (p == 0) cmp("pull-ups", 32'(rnd), 32'(pu));
         repeat (3) @(posedge pclk);
         rchk("port pins", 10'h006 + 10'(p), 32'((d & ~rnd) | ((p == 2 ? bus_drv : ext_b) & rnd)));
         rnd = lfsr(rnd);
      end
      apb(1'b1, 10'h087, 8'hF0);
      ovr_en <= 8'h0F;
      ovr_in <= 8'h05;
      repeat (2) @(posedge pclk);
      cmp("override oe_n", 32'h0000_00F5, 32'(third_oe_n));
      ovr_en <= 8'h00;
      apb(1'b1, 10'h09F, 8'h06);
      repeat (3) @(posedge pclk);
      rchk("fifth digital", 10'h009, 32'h0000_0007);
      apb(1'b1, 10'h009, rnd);
      cmp("fifth out", 32'(rnd[2:0]), 32'(fifth_out));
      // Two external writes into slave mode, the second overflows
      apb(1'b1, 10'h089, 8'h17);
      for (int n = 0; n < 2; n++) begin
         q = rnd;
         rnd = lfsr(rnd);
         i_ext.ext_write(q);
         m_ov = m_if;
         m_if = 1;
      end
      rchk("in full", 10'h089, fdir(0));
      cmp("irq write", 32'h0000_0001, 32'(irq));
      rchk("input latch", 10'h008, 32'(q));
      m_if = 0;
      rchk("full cleared", 10'h089, fdir(0));
      apb(1'b1, 10'h089, 8'h17);
      apb(1'b1, 10'h08C, 8'h01);
      m_ov = 0;
      cmp("irq clear", 32'h0000_0000, 32'(irq));
      // External read of the output latch
      apb(1'b1, 10'h008, rnd);
      rchk("out full", 10'h089, fdir(1));
      i_ext.ext_read(d);
      cmp("ext read", 32'(rnd), 32'(d));
      rchk("out emptied", 10'h089, fdir(0));
      cmp("irq read", 32'h0000_0001, 32'(irq));
      // Mid-run reset: latches kept, directions and flags back
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp("kept latch", 32'(rnd), 32'(fourth_out));
      cmp("irq reset", 32'h0000_0000, 32'(irq));
      rchk("dir after reset", 10'h088, 32'h0000_00FF);
      give_verdict();
   end
endmodule
